// File: design/mhi_ready_irq.sv
// Sender and receiver frame interrupt status, clear and enable registers
//
// Operation
// - Combined bit 2 set while any channel pends
// - Combined bit cleared only via channel sources
// - Status bit 1 latches ready-lost event
// - Status bit 0 latches ready-gained event
// - Clear bit 1 one clears ready-lost flag
// - Clear bit 0 one clears ready-gained flag
// - Zeros ignored; clear write-only; upper bits ignored
// - Enable bit 2 read-only, reads one in sender frame, zero in receiver frame
// - Enable bit 1 ready-lost, resets zero
// - Enable bit 0 ready-gained, resets zero
// - Event interrupt raised only while enabled
// - Receiver clear register writes do nothing
// - Readiness flag one means receiver accepts
`timescale 1ns/1ps
module mhi_ready_irq (
	input  wire logic               mclk,
	input  wire logic               rst,
	input  wire mhi_pkg::mhi_av_req_t av_req,
	output mhi_pkg::mhi_av_rsp_t    av_rsp,
	input  wire logic               receiver_can_accept,
	input  wire logic [123:0]       sender_chan_pending,
	input  wire logic [123:0]       receiver_chan_pending,
	output logic                    sender_irq,
	output logic                    receiver_irq
);
	import mhi_pkg::*;

	logic       ready_sync;
	logic       ready_prev;
	logic       ready_lost_event;
	logic       ready_gained_event;
	logic [1:0] event_flags;
	logic [1:0] event_en;
	logic       any_sender_pending;
	logic       any_receiver_pending;
	logic       access;
	logic       wr_hit;
	logic       rd_hit;
	logic       sel_frame;
	logic [11:0] sel_off;
	logic       clr_lost;
	logic       clr_gained;
	logic [31:0] next_rdata;
	logic       wait_q;
	logic [31:0] rdata_q;

	// Readiness comes from the receiver side, possibly another clock
	mhi_sync2 u_ready_sync (
		.mclk     (mclk),
		.rst      (rst),
		.async_in (receiver_can_accept),
		.sync_out (ready_sync)
	);

	always_ff @(posedge mclk) begin
		if (rst) begin
			ready_prev <= RST_SYNC;
		end else begin
			ready_prev <= ready_sync;
		end
	end

	assign ready_lost_event   = ready_prev & ~ready_sync;
	assign ready_gained_event = ~ready_prev & ready_sync;

	// Bus decode; a write completes on the edge where waitrequest is low, read data is captured on the edge where it is high
	assign access    = av_req.read | av_req.write;
	assign wr_hit    = av_req.write & ~av_rsp.waitrequest;
	assign rd_hit    = av_req.read & av_rsp.waitrequest;
	assign sel_frame = av_req.address[FRAME_BIT];
	assign sel_off   = av_req.address[11:0];

	assign clr_lost   = wr_hit && sel_frame == FRAME_SENDER && sel_off == OFF_CLEAR
		&& av_req.byteenable[0] && av_req.writedata[BIT_LOST];
	assign clr_gained = wr_hit && sel_frame == FRAME_SENDER && sel_off == OFF_CLEAR
		&& av_req.byteenable[0] && av_req.writedata[BIT_GAINED];

	// Waitrequest drops for one cycle per request
	always_ff @(posedge mclk) begin
		if (rst) begin
			wait_q <= 1'b1;
		end else if (access && wait_q) begin
			wait_q <= 1'b0;
		end else begin
			wait_q <= 1'b1;
		end
	end

	// Sticky event flags; a new event wins over a clear
	always_ff @(posedge mclk) begin
		if (rst) begin
			event_flags <= RST_FLAGS;
		end else begin
			event_flags[BIT_LOST]   <= ready_lost_event
				| (event_flags[BIT_LOST] & ~clr_lost);
			event_flags[BIT_GAINED] <= ready_gained_event
				| (event_flags[BIT_GAINED] & ~clr_gained);
		end
	end

	// Sender enables; receiver frame holds no writable enable here
	always_ff @(posedge mclk) begin
		if (rst) begin
			event_en <= RST_EVENT_EN;
		end else if (wr_hit && sel_frame == FRAME_SENDER && sel_off == OFF_ENABLE
			&& av_req.byteenable[0]) begin
			event_en[BIT_LOST]   <= av_req.writedata[BIT_LOST];
			event_en[BIT_GAINED] <= av_req.writedata[BIT_GAINED];
		end
	end

	// Combined summaries follow the channel sources only
	always_ff @(posedge mclk) begin
		if (rst) begin
			any_sender_pending   <= 1'b0;
			any_receiver_pending <= 1'b0;
		end else begin
			any_sender_pending   <= |sender_chan_pending;
			any_receiver_pending <= |receiver_chan_pending;
		end
	end

	// Interrupt outputs
	always_ff @(posedge mclk) begin
		if (rst) begin
			sender_irq   <= 1'b0;
			receiver_irq <= 1'b0;
		end else begin
			sender_irq   <= (|(event_flags & event_en))
				| (any_sender_pending & RST_COMB_EN);
			receiver_irq <= any_receiver_pending & RST_COMB_EN;
		end
	end

	// Read mux; reserved and unmapped locations read zero
	always_comb begin
		next_rdata = 32'h0000_0000;
		if (sel_frame == FRAME_SENDER) begin
			unique case (sel_off)
				OFF_STATUS: begin
					next_rdata[BIT_COMB]   = any_sender_pending;
					next_rdata[BIT_LOST]   = event_flags[BIT_LOST];
					next_rdata[BIT_GAINED] = event_flags[BIT_GAINED];
				end
				OFF_ENABLE: begin
					next_rdata[BIT_COMB]   = RST_COMB_EN;
					next_rdata[BIT_LOST]   = event_en[BIT_LOST];
					next_rdata[BIT_GAINED] = event_en[BIT_GAINED];
				end
				default: begin
					next_rdata = 32'h0000_0000;
				end
			endcase
		end else if (sel_off == OFF_STATUS) begin
			next_rdata[BIT_COMB] = any_receiver_pending;
		end
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			rdata_q <= RST_RDATA;
		end else if (rd_hit) begin
			rdata_q <= next_rdata;
		end
	end

	assign av_rsp = '{readdata: rdata_q, waitrequest: wait_q};

	default clocking cb @(posedge mclk); endclocking
	default disable iff (rst);

	property p_comb_tracks;
		##1 any_sender_pending == $past(|sender_chan_pending);
	endproperty
	a_comb_tracks: assert property (p_comb_tracks) else $error("combined bit stale");

	property p_comb_fall;
		$fell(any_sender_pending) |-> $past(sender_chan_pending) == 124'h0;
	endproperty
	a_comb_fall: assert property (p_comb_fall) else $error("combined fell early");

	property p_lost_set;
		ready_lost_event |=> event_flags[BIT_LOST];
	endproperty
	a_lost_set: assert property (p_lost_set) else $error("lost flag not set");

	property p_gained_set;
		ready_gained_event |=> event_flags[BIT_GAINED];
	endproperty
	a_gained_set: assert property (p_gained_set) else $error("gained flag not set");

	property p_lost_clr;
		clr_lost && !ready_lost_event |=> !event_flags[BIT_LOST];
	endproperty
	a_lost_clr: assert property (p_lost_clr) else $error("lost flag not cleared");

	property p_gained_clr;
		clr_gained && !ready_gained_event |=> !event_flags[BIT_GAINED];
	endproperty
	a_gained_clr: assert property (p_gained_clr) else $error("gained flag not cleared");

	property p_zero_keeps;
		event_flags[BIT_LOST] && !clr_lost |=> event_flags[BIT_LOST];
	endproperty
	a_zero_keeps: assert property (p_zero_keeps) else $error("flag lost without clear");

	property p_comb_en_one;
		rd_hit && sel_frame == FRAME_SENDER && sel_off == OFF_ENABLE
			|=> av_rsp.readdata[BIT_COMB] && av_rsp.readdata[31:3] == 29'h0;
	endproperty
	a_comb_en_one: assert property (p_comb_en_one) else $error("enable bit 2 not one");

	property p_en_write;
		wr_hit && sel_frame == FRAME_SENDER && sel_off == OFF_ENABLE && av_req.byteenable[0]
			|=> event_en == $past(av_req.writedata[1:0]);
	endproperty
	a_en_write: assert property (p_en_write) else $error("enable not stored");

	property p_irq_gate;
		##1 sender_irq == ($past(|(event_flags & event_en)) | $past(any_sender_pending));
	endproperty
	a_irq_gate: assert property (p_irq_gate) else $error("irq gating wrong");

	property p_rcv_clr_inert;
		wr_hit && sel_frame == FRAME_RECEIVER && sel_off == OFF_CLEAR
			|=> ($past(event_flags) & ~event_flags) == 2'h0 && $stable(event_en);
	endproperty
	a_rcv_clr_inert: assert property (p_rcv_clr_inert) else $error("receiver clear acted");

	property p_wait_one;
		access && av_rsp.waitrequest |=> !av_rsp.waitrequest ##1 av_rsp.waitrequest;
	endproperty
	a_wait_one: assert property (p_wait_one) else $error("waitrequest timing");

	property p_rcv_comb;
		##1 any_receiver_pending == $past(|receiver_chan_pending);
	endproperty
	a_rcv_comb: assert property (p_rcv_comb) else $error("receiver combined bit stale");

	property p_comb_rise;
		$rose(any_sender_pending) |-> $past(sender_chan_pending) != 124'h0;
	endproperty
	a_comb_rise: assert property (p_comb_rise) else $error("combined rose without source");

	property p_rcv_irq;
		##1 receiver_irq == $past(any_receiver_pending);
	endproperty
	a_rcv_irq: assert property (p_rcv_irq) else $error("receiver irq wrong");

	property p_rcv_fall;
		$fell(any_receiver_pending) |-> $past(receiver_chan_pending) == 124'h0;
	endproperty
	a_rcv_fall: assert property (p_rcv_fall) else $error("receiver combined fell early");

	property p_comb_drives_irq;
		any_sender_pending |=> sender_irq;
	endproperty
	a_comb_drives_irq: assert property (p_comb_drives_irq) else $error("combined irq off");

	property p_gained_keeps;
		event_flags[BIT_GAINED] && !clr_gained |=> event_flags[BIT_GAINED];
	endproperty
	a_gained_keeps: assert property (p_gained_keeps) else $error("gained flag dropped");

	property p_lost_quiet;
		!ready_lost_event && !event_flags[BIT_LOST] |=> !event_flags[BIT_LOST];
	endproperty
	a_lost_quiet: assert property (p_lost_quiet) else $error("lost flag set alone");

	property p_gained_quiet;
		!ready_gained_event && !event_flags[BIT_GAINED] |=> !event_flags[BIT_GAINED];
	endproperty
	a_gained_quiet: assert property (p_gained_quiet) else $error("gained flag set alone");

	property p_en_hold;
		!(wr_hit && sel_frame == FRAME_SENDER && sel_off == OFF_ENABLE) |=> $stable(event_en);
	endproperty
	a_en_hold: assert property (p_en_hold) else $error("enable changed unwritten");

	property p_irq_off;
		event_en == 2'h0 && !any_sender_pending |=> !sender_irq;
	endproperty
	a_irq_off: assert property (p_irq_off) else $error("irq while disabled");

	property p_status_read;
		rd_hit && sel_frame == FRAME_SENDER && sel_off == OFF_STATUS
			|=> av_rsp.readdata == {29'h0, $past(any_sender_pending), $past(event_flags)};
	endproperty
	a_status_read: assert property (p_status_read) else $error("status read wrong");

	property p_clear_reads_zero;
		rd_hit && sel_off == OFF_CLEAR |=> av_rsp.readdata == 32'h0000_0000;
	endproperty
	a_clear_reads_zero: assert property (p_clear_reads_zero) else $error("clear read nonzero");

	property p_rcv_read;
		rd_hit && sel_frame == FRAME_RECEIVER
			|=> av_rsp.readdata[31:3] == 29'h0 && av_rsp.readdata[1:0] == 2'h0;
	endproperty
	a_rcv_read: assert property (p_rcv_read) else $error("receiver reserved bits set");

	property p_sync_delay;
		##2 ready_sync == $past(receiver_can_accept, 2);
	endproperty
	a_sync_delay: assert property (p_sync_delay) else $error("readiness sync delay wrong");

endmodule : mhi_ready_irq

// File: design/mhi_pkg.sv
// Constants and types for the mailbox readiness interrupt block
package mhi_pkg;

	localparam int ADDR_W    = 13;
	localparam int DATA_W    = 32;
	localparam int NUM_CH    = 124;
	localparam int FRAME_BIT = 12;

	// Register offsets inside a frame
	localparam logic [11:0] OFF_STATUS = 12'hf90;
	localparam logic [11:0] OFF_CLEAR  = 12'hf94;
	localparam logic [11:0] OFF_ENABLE = 12'hf98;

	// Frame select value of address bit 12
	localparam logic FRAME_SENDER   = 1'b0;
	localparam logic FRAME_RECEIVER = 1'b1;

	// Field positions in status, clear and enable words
	localparam int BIT_GAINED = 0;
	localparam int BIT_LOST   = 1;
	localparam int BIT_COMB   = 2;

	// Values after reset
	localparam logic [1:0]  RST_EVENT_EN = 2'h0;
	localparam logic [1:0]  RST_FLAGS    = 2'h0;
	localparam logic        RST_COMB_EN  = 1'b1;
	localparam logic [31:0] RST_RDATA    = 32'h0000_0000;
	localparam logic        RST_SYNC     = 1'b0;

	typedef struct packed {
		logic              read;
		logic              write;
		logic [ADDR_W-1:0] address;
		logic [DATA_W-1:0] writedata;
		logic [3:0]        byteenable;
	} mhi_av_req_t;

	typedef struct packed {
		logic [DATA_W-1:0] readdata;
		logic              waitrequest;
	} mhi_av_rsp_t;

endpackage : mhi_pkg

// File: design/mhi_sync2.sv
// Two-stage level synchroniser
`timescale 1ns/1ps
module mhi_sync2 (
	input  wire logic mclk,
	input  wire logic rst,
	input  wire logic async_in,
	output logic      sync_out
);
	import mhi_pkg::*;

	logic meta;

	always_ff @(posedge mclk) begin
		if (rst) begin
			meta     <= RST_SYNC;
			sync_out <= RST_SYNC;
		end else begin
			meta     <= async_in;
			sync_out <= meta;
		end
	end

endmodule : mhi_sync2

// File: dv/mhi_rx_model.sv
// Receiver side model: readiness level and per-channel pending lines
`timescale 1ns/1ps
module mhi_rx_model (
	input  wire logic         mclk,
	input  wire logic         want_ready,
	input  wire logic [123:0] want_pend,
	output logic              receiver_can_accept,
	output logic [123:0]      receiver_chan_pending
);
	// Readiness one means the receiver accepts
	always_ff @(posedge mclk) begin
		receiver_can_accept <= want_ready;
	end

	// Pending follows want_pend, registered one cycle later
	always_ff @(posedge mclk) begin
		receiver_chan_pending <= want_pend;
	end
endmodule : mhi_rx_model

// File: dv/mhi_ready_irq_test.sv
// Self-checking bench of the readiness interrupt registers
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin fail_count++; \
	$display("FAIL %s exp %h got %h", nm, e, g); end end
module mhi_ready_irq_test;
	import mhi_pkg::*;
	logic         mclk;
	logic         rst;
	mhi_av_req_t  req;
	mhi_av_rsp_t  rsp;
	logic         rdy;
	logic         want_ready;
	logic [123:0] want_pend;
	logic [123:0] rx_pend;
	logic [123:0] tx_pend;
	logic         s_irq;
	logic         r_irq;
	logic [31:0]  d;
	int           fail_count;
	int           n_compared;

	mhi_ready_irq mhi_ready_irq_i (.mclk(mclk), .rst(rst), .av_req(req), .av_rsp(rsp),
		.receiver_can_accept(rdy), .sender_chan_pending(tx_pend),
		.receiver_chan_pending(rx_pend), .sender_irq(s_irq), .receiver_irq(r_irq));
	mhi_rx_model mhi_rx_model_i (.mclk(mclk), .want_ready(want_ready), .want_pend(want_pend),
		.receiver_can_accept(rdy), .receiver_chan_pending(rx_pend));

	initial begin
		mclk = 0;
		forever #50 mclk = ~mclk;
	end

	task automatic bus(input logic wr, input logic [12:0] a, input logic [31:0] w);
		@(posedge mclk);
		req.read <= ~wr;
		req.write <= wr;
		req.address <= a;
		req.writedata <= w;
		do begin
			@(posedge mclk);
		end while (rsp.waitrequest !== 1'b0);
		d = rsp.readdata;
		req.read <= 1'b0;
		req.write <= 1'b0;
	endtask : bus

	task automatic rd_chk(input logic [12:0] a, input logic [31:0] e);
		bus(1'b0, a, 32'h0000_0000);
		`CHK("readdata", e, d)
	endtask : rd_chk

	task automatic t_reset();
		rd_chk(13'h0f90, 32'h0000_0000);
		`CHK("sender_irq", 1'b0, s_irq)
		`CHK("receiver_irq", 1'b0, r_irq)
		rd_chk(13'h0f98, 32'h0000_0004);
		rd_chk(13'h1f98, 32'h0000_0000);
		bus(1'b1, 13'h0f98, 32'h0000_0000);
		rd_chk(13'h0f98, 32'h0000_0004);
		rd_chk(13'h0f94, 32'h0000_0000);
		rd_chk(13'h0f9c, 32'h0000_0000);
		$display("test reset done");
	endtask : t_reset

	task automatic t_events();
		bus(1'b1, 13'h0f98, 32'hffff_fffb);
		rd_chk(13'h0f98, 32'h0000_0007);
		want_ready <= 1'b1;
		repeat (6) @(posedge mclk);
		rd_chk(13'h0f90, 32'h0000_0001);
		`CHK("sender_irq", 1'b1, s_irq)
		bus(1'b1, 13'h0f94, 32'hffff_fffc);
		rd_chk(13'h0f90, 32'h0000_0001);
		req.byteenable <= 4'he;
		bus(1'b1, 13'h0f94, 32'h0000_0001);
		req.byteenable <= 4'hf;
		rd_chk(13'h0f90, 32'h0000_0001);
		bus(1'b1, 13'h1f94, 32'h0000_0003);
		rd_chk(13'h0f90, 32'h0000_0001);
		bus(1'b1, 13'h0f94, 32'h0000_0001);
		rd_chk(13'h0f90, 32'h0000_0000);
		`CHK("sender_irq", 1'b0, s_irq)
		want_ready <= 1'b0;
		repeat (6) @(posedge mclk);
		rd_chk(13'h0f90, 32'h0000_0002);
		`CHK("sender_irq", 1'b1, s_irq)
		bus(1'b1, 13'h0f98, 32'h0000_0001);
		repeat (2) @(posedge mclk);
		`CHK("sender_irq", 1'b0, s_irq)
		bus(1'b1, 13'h0f94, 32'h0000_0002);
		rd_chk(13'h0f90, 32'h0000_0000);
		$display("test events done");
	endtask : t_events

	task automatic t_comb();
		tx_pend <= 124'h1 << 123;
		want_pend <= 124'h1;
		repeat (4) @(posedge mclk);
		rd_chk(13'h0f90, 32'h0000_0004);
		rd_chk(13'h1f90, 32'h0000_0004);
		`CHK("receiver_irq", 1'b1, r_irq)
		`CHK("sender_irq", 1'b1, s_irq)
		bus(1'b1, 13'h0f94, 32'hffff_ffff);
		rd_chk(13'h0f90, 32'h0000_0004);
		tx_pend <= '0;
		want_pend <= '0;
		repeat (4) @(posedge mclk);
		rd_chk(13'h0f90, 32'h0000_0000);
		rd_chk(13'h1f90, 32'h0000_0000);
		`CHK("receiver_irq", 1'b0, r_irq)
		`CHK("sender_irq", 1'b0, s_irq)
		$display("test combined done");
	endtask : t_comb

	task automatic print_verdict();
		$display("compared %0d mismatched %0d", n_compared, fail_count);
		if (fail_count == 0 && n_compared > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask : print_verdict

	initial begin
		#2_000_000;
		fail_count++;
		print_verdict();
	end

	initial begin
		fail_count = 0;
		n_compared = 0;
		rst = 1'b1;
		req = '0;
		req.byteenable = 4'hf;
		want_ready = 1'b0;
		want_pend = '0;
		tx_pend = '0;
		repeat (4) @(posedge mclk);
		rst <= 1'b0;
		repeat (3) @(posedge mclk);
		t_reset();
		t_events();
		t_comb();
		print_verdict();
	end
endmodule : mhi_ready_irq_test
